/* File: core/asq_sequencer_ctrl.v */
// Sample sequencer control: triggers, priority, FIFOs, overflow
`timescale 1ns/100ps
`include "asq_map.vh"
module asq_sequencer_ctrl #(
    parameter       DATA_W     = `ASQ_DATA_W,      // Sample width
    parameter [7:0] PHASE_STEP = `ASQ_PHASE_STEP_CYC // Cycles per step
) (
    input  wire              ref_clk_in,         // System clock
    input  wire              reset_in,           // Sync reset, high
    input  wire [3:0]        seq_enable_in,      // Enable per sequence
    input  wire [15:0]       seq_trig_sel_in,    // Source, 4 bits each
    input  wire [7:0]        seq_prio_in,        // Priority, 2 bits each
    input  wire [3:0]        phase_delay_in,     // Steps of 22.5 deg
    input  wire              ref_sel_in,         // Reference request
    output wire              ref_sel_out,        // Reference in effect
    output wire              int_ref_en_out,     // Internal 3V ref on
    input  wire              proc_trig_in,       // Processor trigger
    input  wire [1:0]        proc_trig_seq_in,   // Target sequence
    input  wire              proc_trig_wait_in,  // Wait option
    input  wire              proc_trig_signal_in,// Signal option
    input  wire              sync_release_in,    // Signal from peer
    output wire              sync_signal_out,    // Signal to peers
    input  wire [2:0]        analog_cmp_trig_in, // Comparator events
    input  wire              ext_trig_pin_in,    // Dedicated trigger pin
    input  wire              timer_trig_in,      // Timer event
    input  wire [3:0]        pwm_gen_trig_in,    // PWM generator events
    output wire              conv_req_out,       // Sample request
    output wire [1:0]        conv_seq_out,       // Sequence sampling
    output wire [2:0]        conv_step_out,      // Step in sequence
    input  wire              conv_ack_in,        // Sample done pulse
    input  wire [DATA_W-1:0] conv_data_in,       // Sample value
    input  wire [3:0]        rd_ready_in,        // Reader pops word
    output wire [3:0]        rd_valid_out,       // Word available
    output wire [4*DATA_W-1:0] rd_data_out,      // Oldest words
    output wire [15:0]       fill_count_out,     // Words held, 4 each
    output wire [3:0]        overflow_out,       // Sticky overflow
    input  wire [3:0]        overflow_clr_in,    // Clear overflow
    output wire [3:0]        seq_busy_out        // Sequence running
);
    // Sequencer states
    localparam [1:0] ST_IDLE   = 2'b00;
    localparam [1:0] ST_DELAY  = 2'b01;
    localparam [1:0] ST_SAMPLE = 2'b10;

    reg  [1:0]  state_ff;     // Current state
    reg  [1:0]  nxt_state;    // Next state
    reg  [1:0]  cur_seq_ff;   // Sequence being run
    reg  [1:0]  nxt_cur_seq;  // Next sequence
    reg  [11:0] dly_cnt_ff;   // Phase delay countdown
    reg  [11:0] nxt_dly_cnt;  // Next countdown
    reg  [3:0]  smp_cnt_ff;   // Samples taken this run
    reg  [3:0]  nxt_smp_cnt;  // Next sample count
    reg  [3:0]  pend_ff;      // Edge trigger waiting per sequence
    reg  [3:0]  nxt_pend;     // Next pending
    reg  [3:0]  wait_ff;      // Held wait-option trigger
    reg  [3:0]  nxt_wait;     // Next held trigger
    reg  [3:0]  ovf_ff;       // Sticky overflow
    reg  [3:0]  nxt_ovf;      // Next overflow
    reg         ref_ff;       // Reference selection
    reg         sig_ff;       // Signal pulse to peers
    reg         win_ok;       // A sequence is ready to launch
    reg  [1:0]  win_idx;      // Winning sequence
    integer     p;            // Priority loop index
    integer     s;            // Sequence loop index
    integer     f;            // Flag loop index

    wire        ext_evt;      // Synchronised pin edge
    wire [3:0]  src_evt;      // Selected trigger event per sequence
    wire [3:0]  is_always;    // Sequence uses continuous trigger
    wire [3:0]  is_proc;      // Sequence uses processor trigger
    wire [3:0]  ready_vec;    // Sequence may be launched
    wire [3:0]  launch;       // Sequence launches this cycle
    wire [3:0]  hit;          // Trigger counted for overflow
    wire [3:0]  fifo_wr_rdy;  // FIFO has room
    wire [3:0]  fifo_wr_val;  // FIFO write strobe
    wire [11:0] dly_total;    // Full phase delay in cycles
    wire        smp_take;     // Sample accepted this cycle

    // Pin passes two flops before edge detect
    asq_pin_sync u_ext_sync (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .pin_in     (ext_trig_pin_in),
        .rise_out   (ext_evt)
    );

    // Samples per run for a sequence index
    function [3:0] seq_depth;
        input [1:0] idx;
        begin
            case (idx)
                2'b00:   seq_depth = `ASQ_DEPTH_SEQ0;
                2'b01:   seq_depth = `ASQ_DEPTH_SEQ1;
                2'b10:   seq_depth = `ASQ_DEPTH_SEQ2;
                default: seq_depth = `ASQ_DEPTH_SEQ3;
            endcase
        end
    endfunction

    // Event of the selected source every source is an
    // argument so the caller's assignment follows each event
    function trig_pick;
        input [3:0] sel;
        input       proc_evt;
        input       launch_evt;
        input [2:0] cmp_evt;
        input       pin_evt;
        input       tmr_evt;
        input [3:0] pwm_evt;
        begin
            case (sel)
                `ASQ_TRIG_PROC:   trig_pick = proc_evt;
                `ASQ_TRIG_CMP0:   trig_pick = cmp_evt[0];
                `ASQ_TRIG_CMP1:   trig_pick = cmp_evt[1];
                `ASQ_TRIG_CMP2:   trig_pick = cmp_evt[2];
                `ASQ_TRIG_EXT:    trig_pick = pin_evt;
                `ASQ_TRIG_TIMER:  trig_pick = tmr_evt;
                `ASQ_TRIG_PWM0:   trig_pick = pwm_evt[0];
                `ASQ_TRIG_PWM1:   trig_pick = pwm_evt[1];
                `ASQ_TRIG_PWM2:   trig_pick = pwm_evt[2];
                `ASQ_TRIG_PWM3:   trig_pick = pwm_evt[3];
                `ASQ_TRIG_ALWAYS: trig_pick = launch_evt;
                default:          trig_pick = 1'b0;
            endcase
        end
    endfunction

    // Per-sequence trigger decode and output FIFO
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_seq
            wire [3:0] sel = seq_trig_sel_in[4*g+3:4*g];
            wire       hit_now = proc_trig_in &&
                       (proc_trig_seq_in == g[1:0]) && is_proc[g];
            // Immediate or released processor trigger
            wire       proc_evt = (hit_now & ~proc_trig_wait_in) |
                       (wait_ff[g] & sync_release_in);
            wire [3:0] cnt;

            assign is_always[g] = (sel == `ASQ_TRIG_ALWAYS);
            assign is_proc[g]   = (sel == `ASQ_TRIG_PROC);
            assign src_evt[g]   = trig_pick(sel, proc_evt, launch[g],
                                  analog_cmp_trig_in, ext_evt,
                                  timer_trig_in, pwm_gen_trig_in);
            // Continuous source is ready whenever enabled
            assign ready_vec[g] = seq_enable_in[g] &
                                  (pend_ff[g] | is_always[g]);
            assign launch[g]    = win_ok & (win_idx == g[1:0]) &
                                  (state_ff == ST_IDLE);
            assign hit[g]       = seq_enable_in[g] & src_evt[g];
            assign fifo_wr_val[g] = smp_take & (cur_seq_ff == g[1:0]);
            assign seq_busy_out[g] = (state_ff != ST_IDLE) &
                                     (cur_seq_ff == g[1:0]);
            assign fill_count_out[4*g+3:4*g] = cnt;

            // Each sequence owns a FIFO, readable at once
            asq_fifo #(
                .W     (DATA_W),
                .DEPTH (`ASQ_FIFO_DEPTH),
                .AW    (`ASQ_FIFO_AW)
            ) u_fifo (
                .ref_clk_in   (ref_clk_in),
                .reset_in     (reset_in),
                .wr_valid_in  (fifo_wr_val[g]),
                .wr_ready_out (fifo_wr_rdy[g]),
                .wr_data_in   (conv_data_in),
                .rd_valid_out (rd_valid_out[g]),
                .rd_ready_in  (rd_ready_in[g]),
                .rd_data_out  (rd_data_out[DATA_W*g+DATA_W-1:DATA_W*g]),
                .count_out    (cnt)
            );
        end
    endgenerate

    // Lowest priority number wins; ties fall to lower index
    always @* begin
        win_ok  = 1'b0;
        win_idx = 2'b00;
        for (p = 3; p >= 0; p = p - 1) begin
            for (s = 3; s >= 0; s = s - 1) begin
                if (ready_vec[s] &&
                    seq_prio_in[2*s+:2] == p[1:0]) begin
                    win_ok  = 1'b1;
                    win_idx = s[1:0];
                end
            end
        end
    end

    // Phase delay shared by every sequence
    assign dly_total = phase_delay_in * PHASE_STEP;

    // Sample accepted only when its FIFO has room
    assign smp_take = conv_req_out & conv_ack_in;
    assign conv_req_out = (state_ff == ST_SAMPLE) &
                          seq_enable_in[cur_seq_ff] &
                          fifo_wr_rdy[cur_seq_ff];
    assign conv_seq_out  = cur_seq_ff;
    assign conv_step_out = smp_cnt_ff[2:0];

    // Run state machine
    always @* begin
        nxt_state   = state_ff;
        nxt_cur_seq = cur_seq_ff;
        nxt_dly_cnt = dly_cnt_ff;
        nxt_smp_cnt = smp_cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                // Start the winner on its trigger
                if (win_ok) begin
                    nxt_cur_seq = win_idx;
                    nxt_smp_cnt = 4'h0;
                    if (dly_total == 12'h000) begin
                        nxt_state = ST_SAMPLE;
                    end else begin
                        nxt_state   = ST_DELAY;
                        nxt_dly_cnt = dly_total - 12'h001;
                    end
                end
            end
            ST_DELAY: begin
                // Abort if disabled mid-run
                if (!seq_enable_in[cur_seq_ff]) begin
                    nxt_state = ST_IDLE;
                end else if (dly_cnt_ff == 12'h000) begin
                    nxt_state = ST_SAMPLE;
                end else begin
                    nxt_dly_cnt = dly_cnt_ff - 12'h001;
                end
            end
            ST_SAMPLE: begin
                if (!seq_enable_in[cur_seq_ff]) begin
                    nxt_state = ST_IDLE;
                end else if (smp_take) begin
                    nxt_smp_cnt = smp_cnt_ff + 4'h1;
                    // Stop after the sequence depth
                    if (smp_cnt_ff + 4'h1 == seq_depth(cur_seq_ff)) begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Pending, wait and overflow flags
    always @* begin
        for (f = 0; f < 4; f = f + 1) begin
            // Edge triggers remembered until launch; set wins
            if (!seq_enable_in[f]) begin
                nxt_pend[f] = 1'b0;
            end else if (hit[f] && !is_always[f]) begin
                nxt_pend[f] = 1'b1;
            end else if (launch[f]) begin
                nxt_pend[f] = 1'b0;
            end else begin
                nxt_pend[f] = pend_ff[f];
            end
            // Wait option parks the trigger until released
            if (!seq_enable_in[f] || !is_proc[f]) begin
                nxt_wait[f] = 1'b0;
            end else if (proc_trig_in && proc_trig_wait_in &&
                         proc_trig_seq_in == f[1:0]) begin
                nxt_wait[f] = 1'b1;
            end else if (sync_release_in) begin
                nxt_wait[f] = 1'b0;
            end else begin
                nxt_wait[f] = wait_ff[f];
            end
            // Trigger with unread data sets overflow; set wins
            if (hit[f] && fill_count_out[4*f+:4] != 4'h0) begin
                nxt_ovf[f] = 1'b1;
            end else if (overflow_clr_in[f]) begin
                nxt_ovf[f] = 1'b0;
            end else begin
                nxt_ovf[f] = ovf_ff[f];
            end
        end
    end

    // State registers
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_ff   <= ST_IDLE;
            cur_seq_ff <= 2'b00;
            dly_cnt_ff <= 12'h000;
            smp_cnt_ff <= 4'h0;
            pend_ff    <= 4'h0;
            wait_ff    <= 4'h0;
            ovf_ff     <= 4'h0;
            ref_ff     <= `ASQ_REF_INTERNAL;
            sig_ff     <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cur_seq_ff <= nxt_cur_seq;
            dly_cnt_ff <= nxt_dly_cnt;
            smp_cnt_ff <= nxt_smp_cnt;
            pend_ff    <= nxt_pend;
            wait_ff    <= nxt_wait;
            ovf_ff     <= nxt_ovf;
            // Reference selection follows the request
            ref_ff     <= ref_sel_in;
            // Signal option tells peer modules to start
            sig_ff     <= proc_trig_in & proc_trig_signal_in;
        end
    end

    // Status and reference read-back
    assign overflow_out    = ovf_ff;
    assign ref_sel_out     = ref_ff;
    assign int_ref_en_out  = (ref_ff == `ASQ_REF_INTERNAL);
    assign sync_signal_out = sig_ff;
endmodule // asq_sequencer_ctrl

/* File: core/asq_map.vh */
// Constants for the sample sequencer control block
`ifndef ASQ_MAP_VH
`define ASQ_MAP_VH

// Trigger source codes, four bits per sequence
`define ASQ_TRIG_PROC      4'h0
`define ASQ_TRIG_CMP0      4'h1
`define ASQ_TRIG_CMP1      4'h2
`define ASQ_TRIG_CMP2      4'h3
`define ASQ_TRIG_EXT       4'h4
`define ASQ_TRIG_TIMER     4'h5
`define ASQ_TRIG_PWM0      4'h6
`define ASQ_TRIG_PWM1      4'h7
`define ASQ_TRIG_PWM2      4'h8
`define ASQ_TRIG_PWM3      4'h9
`define ASQ_TRIG_ALWAYS    4'ha

// Samples taken per run of each sequence
`define ASQ_DEPTH_SEQ0     4'h8
`define ASQ_DEPTH_SEQ1     4'h4
`define ASQ_DEPTH_SEQ2     4'h4
`define ASQ_DEPTH_SEQ3     4'h1

// Reference selection codes
`define ASQ_REF_INTERNAL   1'b0
`define ASQ_REF_EXTERNAL   1'b1

// Cycles per 22.5 degree phase step
`define ASQ_PHASE_STEP_CYC 8'h01

// Output FIFO shape
`define ASQ_FIFO_DEPTH     8
`define ASQ_FIFO_AW        3
`define ASQ_DATA_W         12

`endif

/* File: core/asq_pin_sync.v */
// Two-flop pin synchroniser with rising edge pulse
`timescale 1ns/100ps
module asq_pin_sync (
    input  wire ref_clk_in,   // System clock
    input  wire reset_in,     // Synchronous reset, active high
    input  wire pin_in,       // Asynchronous pin level
    output wire rise_out      // One-cycle pulse on rising edge
);
    reg meta_ff;   // First stage, read only by second stage
    reg sync_ff;   // Second stage, safe level
    reg prev_ff;   // Previous safe level for edge detect

    // Shift the pin through the synchroniser
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge seen only on the settled stages
    assign rise_out = sync_ff & ~prev_ff;
endmodule // asq_pin_sync

/* File: core/asq_fifo.v */
// Parameterised sample FIFO with valid/ready on both sides
`timescale 1ns/100ps
module asq_fifo #(
    parameter W     = 12,   // Word width
    parameter DEPTH = 8,    // Number of words
    parameter AW    = 3     // Pointer width, log2 of DEPTH
) (
    input  wire          ref_clk_in,  // System clock
    input  wire          reset_in,    // Synchronous reset, active high
    input  wire          wr_valid_in, // Write word offered
    output wire          wr_ready_out,// Room for a word
    input  wire [W-1:0]  wr_data_in,  // Word to store
    output wire          rd_valid_out,// Word available
    input  wire          rd_ready_in, // Reader takes the word
    output wire [W-1:0]  rd_data_out, // Oldest word
    output wire [AW:0]   count_out    // Words held
);
    reg [W-1:0] mem [0:DEPTH-1];  // Storage
    reg [AW-1:0] wp_ff;           // Write pointer
    reg [AW-1:0] rp_ff;           // Read pointer
    reg [AW:0]   cnt_ff;          // Fill level

    wire do_wr = wr_valid_in & wr_ready_out;  // Accepted write
    wire do_rd = rd_valid_out & rd_ready_in;  // Accepted read

    assign wr_ready_out = (cnt_ff != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_ff != {(AW+1){1'b0}});
    assign rd_data_out  = mem[rp_ff];
    assign count_out    = cnt_ff;

    // Storage write, no reset needed for data
    always @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wp_ff] <= wr_data_in;
        end
    end

    // Pointers and fill level
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            wp_ff  <= {AW{1'b0}};
            rp_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp_ff <= (wp_ff == DEPTH[AW-1:0] - 1'b1) ?
                         {AW{1'b0}} : wp_ff + 1'b1;
            end
            if (do_rd) begin
                rp_ff <= (rp_ff == DEPTH[AW-1:0] - 1'b1) ?
                         {AW{1'b0}} : rp_ff + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (do_rd & ~do_wr) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // asq_fifo

/* File: bench/asq_conv_model.sv */
// Converter model that answers sample requests
`timescale 1ns/100ps
module asq_conv_model (
    input  wire         ref_clk_in,    // System clock
    input  wire         reset_in,      // Sync reset, high
    input  wire         conv_req_in,   // Sample request
    input  wire  [1:0]  conv_seq_in,   // Sequence sampling
    input  wire  [2:0]  conv_step_in,  // Step in sequence
    input  wire         slow_in,       // Answer one cycle in four
    output logic        conv_ack_out,  // Sample done pulse
    output logic [11:0] conv_data_out  // Sample value
);
    logic [1:0]  gap_ff;   // Stall counter for slow answers
    logic [11:0] last_ff;  // Last answered value
    // Ack is spaced out so the step index settles between samples
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            gap_ff <= 2'h0;
            conv_ack_out <= 1'b0;
            last_ff <= 12'h000;
        end else begin
            gap_ff <= gap_ff + 2'h1;
            conv_ack_out <= conv_req_in && !conv_ack_out
                            && (!slow_in || gap_ff == 2'h3);
            if (conv_ack_out) last_ff <= conv_data_out;
        end
    end
    // Off the ack the data line shows the inverse of the last value
    assign conv_data_out = conv_ack_out ?
        {conv_seq_in, conv_step_in, 7'h2a} : ~last_ff;
endmodule // asq_conv_model

/* File: bench/asq_sva_assertions.sv */
// Port checker for the sample sequencer control
`timescale 1ns/100ps
module asq_sva (
    input wire        ref_clk_in,          // Clock
    input wire        reset_in,            // Reset
    input wire [3:0]  seq_enable_in,       // Enables
    input wire [15:0] seq_trig_sel_in,     // Sources
    input wire        timer_trig_in,       // Timer event
    input wire        ref_sel_in,          // Reference request
    input wire        ref_sel_out,         // Reference in effect
    input wire        int_ref_en_out,      // Internal ref on
    input wire        proc_trig_in,        // Processor trigger
    input wire        proc_trig_signal_in, // Signal option
    input wire        sync_signal_out,     // Signal to peers
    input wire        conv_req_out,        // Sample request
    input wire [1:0]  conv_seq_out,        // Sequence sampling
    input wire [2:0]  conv_step_out,       // Step
    input wire        conv_ack_in,         // Sample done
    input wire [3:0]  rd_ready_in,         // Pops
    input wire [3:0]  rd_valid_out,        // Words available
    input wire [15:0] fill_count_out,      // Fill counts
    input wire [3:0]  overflow_out,        // Overflow flags
    input wire [3:0]  overflow_clr_in,     // Clears
    input wire [3:0]  seq_busy_out         // Running
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    property p_ref; 1'b1 |=> ref_sel_out == $past(ref_sel_in); endproperty
    a_ref: assert property (p_ref) else $error("ref lag");
    property p_iref; int_ref_en_out == !ref_sel_out; endproperty
    a_iref: assert property (p_iref) else $error("int ref");
    property p_sig; proc_trig_in && proc_trig_signal_in |=> sync_signal_out;
    endproperty
    a_sig: assert property (p_sig) else $error("no signal");
    property p_fill; conv_req_out && conv_ack_in && conv_seq_out == 2'h0
        && !rd_ready_in[0] |=> fill_count_out[3:0] ==
        $past(fill_count_out[3:0]) + 4'h1; endproperty
    a_fill: assert property (p_fill) else $error("fill count");
    property p_val; rd_valid_out[3] == (fill_count_out[15:12] != 4'h0);
    endproperty
    a_val: assert property (p_val) else $error("valid");
    property p_full; conv_req_out |->
        fill_count_out[conv_seq_out*4 +: 4] != 4'h8; endproperty
    a_full: assert property (p_full) else $error("req full");
    property p_stk; overflow_out[3] && !overflow_clr_in[3] |=>
        overflow_out[3]; endproperty
    a_stk: assert property (p_stk) else $error("ovf lost");
    property p_clr; overflow_clr_in[3] && !seq_enable_in[3] |=>
        !overflow_out[3]; endproperty
    a_clr: assert property (p_clr) else $error("ovf clear");
    property p_dis; !seq_enable_in[3] [*2] |-> !seq_busy_out[3]; endproperty
    a_dis: assert property (p_dis) else $error("disabled runs");
    property p_trig; seq_enable_in == 4'h8 && timer_trig_in &&
        seq_trig_sel_in[15:12] == 4'h5 && seq_busy_out == 4'h0 |->
        ##2 seq_busy_out[3]; endproperty
    a_trig: assert property (p_trig) else $error("no launch");
    property p_step; conv_req_out && conv_seq_out == 2'h3 |->
        conv_step_out == 3'h0; endproperty
    a_step: assert property (p_step) else $error("step");
    c_run: cover property (seq_busy_out[3] && conv_ack_in);
    c_ovf: cover property ($rose(overflow_out[3]));
    c_full: cover property (fill_count_out[15:12] == 4'h8);
endmodule // asq_sva
bind asq_sequencer_ctrl asq_sva u_sva (.*);

/* File: bench/testbench.sv */
// Self-checking bench for the sample sequencer control
`timescale 1ns/100ps
module testbench;
    logic        ref_clk_in = 1'b0; // Clock
    logic        reset_in = 1'b1;   // Reset
    logic [3:0]  en = 4'h0;         // Enables
    logic [15:0] sel = 16'h0000;    // Sources
    logic [7:0]  prio = 8'he4;      // Distinct priorities
    logic [3:0]  ph = 4'h0;         // Phase steps
    logic        rsel = 1'b0, pt = 1'b0, pw = 1'b0, ps = 1'b0;
    logic        srel = 1'b0, ext = 1'b0, tmr = 1'b0, slow = 1'b0;
    logic [2:0]  cmp = 3'h0;        // Comparator events
    logic [3:0]  pwm = 4'h0, rdy = 4'h0, oclr = 4'h0;
    logic [1:0]  pseq = 2'h0;       // Processor target
    wire         req, ack, ssig, iref, rout;
    wire  [1:0]  cseq;
    wire  [2:0]  cstep;
    wire  [11:0] cdat;
    wire  [3:0]  rval, ovf, busy;
    wire  [47:0] rdat;
    wire  [15:0] fill;
    int          n_mismatch = 0, n_tests = 0, s, c, k;
    int          dep [3] = '{8, 4, 4};
    asq_sequencer_ctrl #(.DATA_W(12), .PHASE_STEP(8'h01)) uut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .seq_enable_in(en), .seq_trig_sel_in(sel), .seq_prio_in(prio),
        .phase_delay_in(ph), .ref_sel_in(rsel), .ref_sel_out(rout),
        .int_ref_en_out(iref), .proc_trig_in(pt), .proc_trig_seq_in(pseq),
        .proc_trig_wait_in(pw), .proc_trig_signal_in(ps),
        .sync_release_in(srel), .sync_signal_out(ssig),
        .analog_cmp_trig_in(cmp), .ext_trig_pin_in(ext),
        .timer_trig_in(tmr), .pwm_gen_trig_in(pwm), .conv_req_out(req),
        .conv_seq_out(cseq), .conv_step_out(cstep), .conv_ack_in(ack),
        .conv_data_in(cdat), .rd_ready_in(rdy), .rd_valid_out(rval),
        .rd_data_out(rdat), .fill_count_out(fill), .overflow_out(ovf),
        .overflow_clr_in(oclr), .seq_busy_out(busy));
    asq_conv_model u_conv (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .conv_req_in(req), .conv_seq_in(cseq), .conv_step_in(cstep),
        .slow_in(slow), .conv_ack_out(ack), .conv_data_out(cdat));
    always #5 ref_clk_in = ~ref_clk_in;
    task tick;
        @(posedge ref_clk_in);
        #1;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Pulse the event input that belongs to source code c
    task fire(input logic [3:0] c, input logic [1:0] s, input logic w, g);
        case (c)
            4'h0: {pt, pseq, pw, ps} = {1'b1, s, w, g};
            4'h1, 4'h2, 4'h3: cmp[c - 4'h1] = 1'b1;
            4'h4: ext = 1'b1;
            4'h5: tmr = 1'b1;
            default: pwm[c - 4'h6] = 1'b1;
        endcase
        tick;
        {pt, pw, ps, ext, tmr, cmp, pwm} = '0;
    endtask
    // Let the pin latency pass, then wait for all runs to end
    task idle;
        repeat (8) tick;
        for (k = 0; k < 300 && busy !== 4'h0; k++) tick;
        tick;
    endtask
    // Pop n words, holding ready up, checking each head word
    task drain(input logic [1:0] s, input int n, input logic z);
        int j;
        rdy[s] = 1'b1;
        for (j = 0; j < n; j++) begin
            chk(rdat[12*s +: 12], {s, z ? 3'h0 : j[2:0], 7'h2a});
            tick;
        end
        rdy[s] = 1'b0;
        tick;
        chk({fill[4*s +: 4], rval[s]}, 24'h0);
    endtask
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (16) tick;
        reset_in = 1'b0;
        tick;
        chk({fill, ovf, rval}, 24'h0);
        chk({rout, iref}, 2'b01);
        rsel = 1'b1;
        tick;
        chk({rout, iref}, 2'b10);
        for (s = 0; s < 3; s++) begin
            slow = (s == 0);
            en = 4'h1 << s;
            fire(4'h0, s[1:0], 1'b0, 1'b0);
            idle;
            chk(fill[4*s +: 4], dep[s]);
            drain(s[1:0], dep[s], 1'b0);
        end
        slow = 1'b0;
        en = 4'h8;
        for (c = 0; c < 10; c++) begin
            sel[15:12] = c[3:0];
            fire(c[3:0], 2'h3, 1'b0, 1'b0);
            idle;
            chk(fill[15:12], 16'h1);
            drain(2'h3, 1, 1'b1);
        end
        slow = 1'b1;
        sel[15:12] = 4'ha;
        repeat (120) tick;
        chk({fill[15:12], req}, 16'h10);
        en = 4'h0;
        oclr = 4'h8;
        tick;
        oclr = 4'h0;
        chk(ovf, 16'h0);
        drain(2'h3, 8, 1'b1);
        slow = 1'b0;
        sel[15:12] = 4'h5;
        en = 4'h8;
        fire(4'h5, 2'h3, 1'b0, 1'b0);
        idle;
        chk(ovf, 16'h0);
        fire(4'h5, 2'h3, 1'b0, 1'b0);
        idle;
        chk(ovf, 16'h8);
        en = 4'h0;
        oclr = 4'h8;
        tick;
        oclr = 4'h0;
        chk(ovf, 16'h0);
        drain(2'h3, 2, 1'b1);
        en = 4'h8;
        fire(4'h0, 2'h3, 1'b0, 1'b0);
        idle;
        chk(fill[15:12], 16'h0);
        en = 4'h0;
        fire(4'h5, 2'h3, 1'b0, 1'b0);
        idle;
        chk(fill[15:12], 16'h0);
        sel[15:12] = 4'h0;
        en = 4'h8;
        fire(4'h0, 2'h3, 1'b1, 1'b0);
        idle;
        chk(fill[15:12], 16'h0);
        srel = 1'b1;
        tick;
        srel = 1'b0;
        idle;
        chk(fill[15:12], 16'h1);
        fire(4'h0, 2'h3, 1'b0, 1'b1);
        chk(ssig, 16'h1);
        idle;
        chk(fill[15:12], 16'h2);
        drain(2'h3, 2, 1'b1);
        sel = 16'h5005;
        prio = 8'h1b;
        en = 4'h9;
        fire(4'h5, 2'h0, 1'b0, 1'b0);
        for (k = 0; k < 9 && req !== 1'b1; k++) tick;
        chk(cseq, 16'h3);
        idle;
        chk(fill, 16'h1008);
        drain(2'h0, 8, 1'b0);
        drain(2'h3, 1, 1'b1);
        en = 4'h8;
        ph = 4'h4;
        fire(4'h5, 2'h3, 1'b0, 1'b0);
        for (k = 0; k < 9 && busy[3] !== 1'b1; k++) tick;
        for (k = 0; k < 20 && req !== 1'b1; k++) tick;
        chk(k, 16'h4);
        idle;
        drain(2'h3, 1, 1'b1);
        finish_test;
    end
endmodule // testbench
